//--- src/remote_io_regs.vh
// Purpose: offsets, field positions and counts of the remote I/O control port
// Assumes: 32-bit register words at aligned byte offsets
// Notes: definitions only
`ifndef REMOTE_IO_REGS_VH
`define REMOTE_IO_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RIO_CTRL 6'h00
`define RIO_PROG 6'h04
`define RIO_MOTORS 6'h08
`define RIO_HOME 6'h0C
`define RIO_HIPWR 6'h10
`define RIO_MACHINE_CALIBRATION 6'h14
`define RIO_ALARM 6'h18
`define RIO_POS 6'h1C
`define RIO_TORQUE 6'h20
`define RIO_LOAD 6'h24
`define RIO_STATUS 6'h28
`define RIO_IRQ_STAT 6'h2C
`define RIO_IRQ_MASK 6'h30
`define RIO_TRIG_POS 6'h34
`define RIO_TRIG_SRC 6'h38
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_AUTO 0
`define CTRL_REMOTE_SEL 1
`define CTRL_PROG_MODE 2
`define CTRL_RIO_EN 3
`define CTRL_QUICK_PAUSE 4
`define CTRL_SAFE_POINT 5
`define CTRL_RESET 6'h00
// ----------------------------------------
// command and event indices
// ----------------------------------------
`define CMD_START 0
`define CMD_PAUSE 1
`define CMD_CONTINUE 2
`define CMD_STOP 3
`define CMD_MOTOR_ON 4
`define CMD_MOTOR_OFF 5
`define CMD_HOME 6
`define EV_MULTI_ERR 7
`define EV_TRIGGER 8
`define EV_REFUSED 9
`define NUM_CMD 7
`define NUM_EV 10
// ----------------------------------------
// timing and trigger bit numbers
// ----------------------------------------
`define PULSE_MS 25
`define SELECT_SETTLE_MS 40
`define CLK_KHZ 200000
`define PULSE_CYC (`PULSE_MS * `CLK_KHZ)
`define NUM_ROBOTS 16
`define TRIG_BITS {9'd313, 9'd312, 9'd281, 9'd280, 9'd57, 9'd56, 9'd25, 9'd24}
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- src/remote_io_control_port.v
// Purpose: remote discrete I/O control and status port with AXI4-Lite registers
// Assumes: 200 MHz clock_i; all pin inputs asynchronous to it
// Notes: pins pass three flops; a level counts once the second and third agree
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "remote_io_regs.vh"
module remote_io_control_port #(
    parameter PULSE_CYC = `PULSE_CYC
) (
    input wire clock_i,
    input wire nrst_i,
    input wire [31:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [31:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire start_i,
    input wire pause_i,
    input wire continue_i,
    input wire stop_i,
    input wire motor_power_on_cmd_i,
    input wire motor_power_off_cmd_i,
    input wire home_i,
    input wire heartbeat_i,
    input wire [4:0] robot_select_in_i,
    input wire [5:0] program_select_in_i,
    input wire [7:0] trigger_i,
    output reg [6:0] cmd_pulse_o,
    output reg [5:0] start_program_o,
    output reg [5:0] program_number_out_o,
    output reg motor_power_flag_o,
    output reg home_flag_o,
    output reg high_power_flag_o,
    output reg calibration_needed_flag_o,
    output reg paused_o,
    output reg alarm_o,
    output reg heartbeat_o,
    output reg [31:0] position_o,
    output reg [31:0] torque_o,
    output reg [31:0] load_o,
    output reg [4:0] report_robot_o,
    output wire irq_o
);
    localparam NIN = 27;
    localparam CW = 24;
    localparam [CW-1:0] PULSE_LIM = PULSE_CYC[CW-1:0];

    function more_than_one;
        input [6:0] v;
        begin
            more_than_one = |(v & (v - 7'h01));
        end
    endfunction

    function [31:0] apply_strobe;
        input [31:0] old;
        input [31:0] d;
        input [3:0] s;
        integer b;
        begin
            apply_strobe = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (s[b]) begin
                    apply_strobe[b*8 +: 8] = d[b*8 +: 8];
                end
            end
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers with agreement filter
    // ----------------------------------------
    wire [NIN-1:0] pins = {heartbeat_i, trigger_i, robot_select_in_i, program_select_in_i,
                           home_i, motor_power_off_cmd_i, motor_power_on_cmd_i, stop_i,
                           continue_i, pause_i, start_i};
    reg [NIN-1:0] s1_r, s2_r, s3_r, lvl_r;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r <= 27'h0;
            s2_r <= 27'h0;
            s3_r <= 27'h0;
            lvl_r <= 27'h0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
        end
    end
    wire [6:0] cmd_lvl = lvl_r[6:0];
    wire [5:0] psel = lvl_r[12:7];
    wire [4:0] rsel = lvl_r[17:13];
    wire [7:0] trig = lvl_r[25:18];
    wire hb = lvl_r[26];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [5:0] ctrl_r;
    reg [15:0] motors_r, home_r, hipwr_r, machine_calibration_r;
    reg [16:0] alarm_r;
    reg [31:0] trig_pos_r;
    reg [7:0] trig_src_r;
    reg [`NUM_EV-1:0] irq_stat_r, irq_mask_r;
    reg [7:0] trig_d_r;

    // ----------------------------------------
    // command qualification
    // ----------------------------------------
    reg [CW-1:0] cnt_r [0:`NUM_CMD-1];
    wire [6:0] fire;
    wire [6:0] held;
    genvar g;
    generate
        for (g = 0; g < `NUM_CMD; g = g + 1) begin : q
            always @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    cnt_r[g] <= 24'h0;
                end else if (!cmd_lvl[g]) begin
                    cnt_r[g] <= 24'h0; // shorter pulses die here
                end else if (cnt_r[g] != PULSE_LIM) begin
                    cnt_r[g] <= cnt_r[g] + 24'h1;
                end
            end
            assign fire[g] = cmd_lvl[g] && cnt_r[g] == PULSE_LIM - 24'h1;
            assign held[g] = cmd_lvl[g] && cnt_r[g] == PULSE_LIM;
        end
    endgenerate

    wire remote_ok = (ctrl_r[`CTRL_AUTO] & ctrl_r[`CTRL_REMOTE_SEL]) |
                     (ctrl_r[`CTRL_PROG_MODE] & ctrl_r[`CTRL_RIO_EN]);
    wire multi = |fire && more_than_one(fire | held);
    wire accept = |fire && remote_ok && !multi;

    // ----------------------------------------
    // robot selection and status flags
    // ----------------------------------------
    wire sel_all = rsel == 5'h00;
    wire sel_ok = rsel <= 5'h10;
    wire [3:0] idx = rsel[3:0] - 4'h1;
    reg pause_pend_r;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            motor_power_flag_o <= 1'b0;
            home_flag_o <= 1'b0;
            high_power_flag_o <= 1'b0;
            calibration_needed_flag_o <= 1'b0;
            alarm_o <= 1'b0;
            heartbeat_o <= 1'b0;
            report_robot_o <= 5'h01;
            cmd_pulse_o <= 7'h00;
            start_program_o <= 6'h00;
            paused_o <= 1'b0;
            pause_pend_r <= 1'b0;
        end else begin
            if (sel_all) begin
                motor_power_flag_o <= |motors_r;
                home_flag_o <= &home_r;
                high_power_flag_o <= |hipwr_r;
                calibration_needed_flag_o <= |(~machine_calibration_r);
            end else begin
                motor_power_flag_o <= sel_ok & motors_r[idx];
                home_flag_o <= sel_ok & home_r[idx];
                high_power_flag_o <= sel_ok & hipwr_r[idx];
                calibration_needed_flag_o <= sel_ok & ~machine_calibration_r[idx];
            end
            // software fills position and torque for this robot
            report_robot_o <= sel_all ? 5'h01 : rsel;
            alarm_o <= |alarm_r;
            heartbeat_o <= hb;
            cmd_pulse_o <= accept ? fire : 7'h00;
            if (accept && fire[`CMD_START]) begin
                start_program_o <= psel;
            end
            // pause waits for a safe point unless quick pause is set
            if (accept && (fire[`CMD_CONTINUE] || fire[`CMD_STOP])) begin
                paused_o <= 1'b0;
                pause_pend_r <= 1'b0;
            end else if (accept && fire[`CMD_PAUSE]) begin
                pause_pend_r <= 1'b1;
            end else if (pause_pend_r &&
                         (ctrl_r[`CTRL_QUICK_PAUSE] || ctrl_r[`CTRL_SAFE_POINT])) begin
                paused_o <= 1'b1;
                pause_pend_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // trigger capture
    // ----------------------------------------
    wire [7:0] trig_rise = trig & ~trig_d_r;
    wire [`NUM_EV-1:0] ev = {~remote_ok & |fire, |trig_rise, |fire & multi,
                             accept ? fire : 7'h00};

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    wire wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
    wire rd_go = s_axi_arvalid_i && !s_axi_rvalid_o;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o = wr_go;
    assign s_axi_arready_o = rd_go;
    wire [5:0] wa = s_axi_awaddr_i[5:0];
    wire [5:0] ra = s_axi_araddr_i[5:0];
    wire wr_hit = s_axi_awaddr_i[31:6] == 26'h0 && wa[1:0] == 2'b00 && wa <= `RIO_IRQ_MASK
                  && wa != `RIO_STATUS && wa != `RIO_IRQ_STAT;
    wire rd_clr = rd_go && ra == `RIO_IRQ_STAT && s_axi_araddr_i[31:6] == 26'h0;
    wire [31:0] wd = s_axi_wdata_i;
    wire [3:0] ws = s_axi_wstrb_i;

    reg [31:0] rd_val;
    reg rd_hit;
    always @* begin
        rd_val = 32'h0;
        rd_hit = s_axi_araddr_i[31:6] == 26'h0 && ra[1:0] == 2'b00;
        case (ra)
            `RIO_CTRL: rd_val = {26'h0, ctrl_r};
            `RIO_PROG: rd_val = {26'h0, program_number_out_o};
            `RIO_MOTORS: rd_val = {16'h0, motors_r};
            `RIO_HOME: rd_val = {16'h0, home_r};
            `RIO_HIPWR: rd_val = {16'h0, hipwr_r};
            `RIO_MACHINE_CALIBRATION: rd_val = {16'h0, machine_calibration_r};
            `RIO_ALARM: rd_val = {15'h0, alarm_r};
            `RIO_POS: rd_val = position_o;
            `RIO_TORQUE: rd_val = torque_o;
            `RIO_LOAD: rd_val = load_o;
            `RIO_STATUS: rd_val = {16'h0, paused_o, start_program_o, rsel, psel[3:0]};
            `RIO_IRQ_STAT: rd_val = {22'h0, irq_stat_r};
            `RIO_IRQ_MASK: rd_val = {22'h0, irq_mask_r};
            `RIO_TRIG_POS: rd_val = trig_pos_r;
            `RIO_TRIG_SRC: rd_val = {24'h0, trig_src_r};
            default: rd_hit = 1'b0;
        endcase
    end

    // current value of the write target, so strobed bytes merge at full width before the cut
    reg [31:0] wr_old;
    always @* begin
        case (wa)
            `RIO_CTRL: wr_old = {26'h0, ctrl_r};
            `RIO_MOTORS: wr_old = {16'h0, motors_r};
            `RIO_HOME: wr_old = {16'h0, home_r};
            `RIO_HIPWR: wr_old = {16'h0, hipwr_r};
            `RIO_MACHINE_CALIBRATION: wr_old = {16'h0, machine_calibration_r};
            `RIO_ALARM: wr_old = {15'h0, alarm_r};
            `RIO_POS: wr_old = position_o;
            `RIO_TORQUE: wr_old = torque_o;
            `RIO_LOAD: wr_old = load_o;
            `RIO_IRQ_MASK: wr_old = {22'h0, irq_mask_r};
            default: wr_old = 32'h0;
        endcase
    end
    wire [31:0] wr_new = apply_strobe(wr_old, wd, ws);

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r <= `CTRL_RESET;
            program_number_out_o <= 6'h00;
            motors_r <= 16'h0;
            home_r <= 16'h0;
            hipwr_r <= 16'h0;
            machine_calibration_r <= 16'hFFFF;
            alarm_r <= 17'h0;
            position_o <= 32'h0;
            torque_o <= 32'h0;
            load_o <= 32'h0;
            irq_mask_r <= 10'h0;
            irq_stat_r <= 10'h0;
            trig_pos_r <= 32'h0;
            trig_src_r <= 8'h00;
            trig_d_r <= 8'h00;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `RESP_OKAY;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `RESP_OKAY;
            s_axi_rdata_o <= 32'h0;
        end else begin
            trig_d_r <= trig;
            // a position is captured on the rising edge of any trigger
            if (|trig_rise) begin
                trig_pos_r <= position_o;
                trig_src_r <= trig_rise;
            end
            // event set wins over the read clear
            irq_stat_r <= (rd_clr ? 10'h0 : irq_stat_r) | ev;
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                if (wr_hit) begin
                    case (wa)
                        `RIO_CTRL: ctrl_r <= wr_new[5:0];
                        `RIO_PROG: program_number_out_o <= ws[0] ? wd[5:0] : program_number_out_o;
                        `RIO_MOTORS: motors_r <= wr_new[15:0];
                        `RIO_HOME: home_r <= wr_new[15:0];
                        `RIO_HIPWR: hipwr_r <= wr_new[15:0];
                        `RIO_MACHINE_CALIBRATION: machine_calibration_r <= wr_new[15:0];
                        `RIO_ALARM: alarm_r <= wr_new[16:0];
                        `RIO_POS: position_o <= wr_new;
                        `RIO_TORQUE: torque_o <= wr_new;
                        `RIO_LOAD: load_o <= wr_new;
                        `RIO_IRQ_MASK: irq_mask_r <= wr_new[9:0];
                        default: ctrl_r <= ctrl_r;
                    endcase
                end
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_val;
                s_axi_rresp_o <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);
endmodule

//--- bench/remote_io_control_port_monitor.sv
// Purpose: concurrent checks on the remote I/O control port pins
// Assumes: control and program words are written with byte 0 enabled
// Notes: shadows of the control and program registers are rebuilt from the write channel
`timescale 1ns/100ps
`include "remote_io_regs.vh"
module remote_io_control_port_monitor #(
    parameter PULSE_CYC = 8
) (
    input wire clock_i,
    input wire nrst_i,
    input wire [31:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire start_i,
    input wire heartbeat_i,
    input wire [4:0] robot_select_in_i,
    input wire [6:0] cmd_pulse_o,
    input wire [5:0] program_number_out_o,
    input wire paused_o,
    input wire heartbeat_o,
    input wire [4:0] report_robot_o
);
// ----------------------------------------
// register shadows and start run length
// ----------------------------------------
wire wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && s_axi_wstrb_i[0];
reg [4:0] ctrl_r;
reg [5:0] prog_r;
reg prog_wr_r;
reg hi_r;
reg [31:0] run_r;
wire rem_ok = (ctrl_r[0] && ctrl_r[1]) || (ctrl_r[2] && ctrl_r[3]);
always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ctrl_r <= 5'h00;
        prog_r <= 6'h00;
        prog_wr_r <= 1'h0;
        hi_r <= 1'h0;
        run_r <= 32'h0;
    end else begin
        prog_wr_r <= wr_go && s_axi_awaddr_i[5:0] == `RIO_PROG;
        if (wr_go && s_axi_awaddr_i[5:0] == `RIO_CTRL) ctrl_r <= s_axi_wdata_i[4:0];
        if (wr_go && s_axi_awaddr_i[5:0] == `RIO_PROG) prog_r <= s_axi_wdata_i[5:0];
        hi_r <= start_i;
        // the run length is kept after release, since the pulse lags the pin
        if (start_i) run_r <= hi_r ? run_r + 32'h1 : 32'h1;
    end
end
default clocking cb @(posedge clock_i); endclocking
default disable iff (!nrst_i);
a_heartbeat_echo: assert property (($stable(heartbeat_i) [*8]) |-> heartbeat_o == heartbeat_i)
    else $error("heartbeat output does not follow its input");
a_pulse_onehot: assert property (cmd_pulse_o != 7'h00 |-> $onehot(cmd_pulse_o))
    else $error("two commands accepted at once");
a_pulse_once: assert property (cmd_pulse_o != 7'h00 |=> cmd_pulse_o == 7'h00)
    else $error("command pulse longer than one cycle");
a_pulse_width: assert property (cmd_pulse_o[0] |-> run_r >= PULSE_CYC)
    else $error("start accepted from a short pulse");
a_remote_gate: assert property (cmd_pulse_o != 7'h00 |-> rem_ok)
    else $error("command accepted while remote control is off");
a_report_one: assert property ((robot_select_in_i == 5'h00) [*8] |-> report_robot_o == 5'h01)
    else $error("robot one not reported under all-robot select");
a_report_pick: assert property (($stable(robot_select_in_i) [*8]) ##0 (robot_select_in_i != 5'h00)
    |-> report_robot_o == robot_select_in_i)
    else $error("reported robot differs from the selected one");
a_prog_follow: assert property (prog_wr_r |-> ##[0:1] program_number_out_o == prog_r)
    else $error("program number output misses the written value");
a_quick_pause: assert property (cmd_pulse_o[1] && ctrl_r[4] |-> ##[1:3] paused_o)
    else $error("paused not raised under quick pause");
a_resume_clear: assert property (cmd_pulse_o[2] || cmd_pulse_o[3] |-> ##[1:3] !paused_o)
    else $error("paused not cleared by continue or stop");
c_start: cover property (cmd_pulse_o[0]);
c_quick: cover property (cmd_pulse_o[1] && ctrl_r[4]);
c_paused: cover property ($rose(paused_o));
endmodule
bind remote_io_control_port remote_io_control_port_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.clock_i, .nrst_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .start_i, .heartbeat_i, .robot_select_in_i, .cmd_pulse_o, .program_number_out_o,
    .paused_o, .heartbeat_o, .report_robot_o);

//--- bench/remote_io_master_model.sv
// Purpose: controlling equipment that drives the remote command, select and trigger pins
// Assumes: the bench clock; pins change by non-blocking assignment after a rising edge
// Notes: select settling is scaled to SETTLE cycles to keep the run short
`timescale 1ns/100ps
module remote_io_master_model #(
    parameter SETTLE = 8
) (
    input wire logic clock_i,
    output logic [6:0] cmd_o,
    output logic heartbeat_o,
    output logic [4:0] robot_select_o,
    output logic [5:0] program_select_o,
    output logic [7:0] trigger_o
);
initial begin
    cmd_o = 7'h00;
    heartbeat_o = 1'h0;
    robot_select_o = 5'h00;
    program_select_o = 6'h00;
    trigger_o = 8'h00;
end
always begin
    repeat (32) @(posedge clock_i);
    heartbeat_o <= ~heartbeat_o;
end
// a one-hot mask keeps one operation at a time; a wider one breaks that on purpose
task automatic pulse(input [6:0] m, input int len);
    @(posedge clock_i);
    cmd_o <= m;
    repeat (len) @(posedge clock_i);
    cmd_o <= 7'h00;
    repeat (SETTLE) @(posedge clock_i);
endtask
task automatic select(input [4:0] s);
    @(posedge clock_i);
    robot_select_o <= s;
    repeat (SETTLE) @(posedge clock_i);
endtask
task automatic prog(input [5:0] p);
    @(posedge clock_i);
    program_select_o <= p;
    repeat (SETTLE) @(posedge clock_i);
endtask
task automatic trig(input int k);
    @(posedge clock_i);
    trigger_o <= 8'h01 << k;
    repeat (8) @(posedge clock_i);
    trigger_o <= 8'h00;
    repeat (8) @(posedge clock_i);
endtask
endmodule

//--- bench/remote_io_control_port_bench.sv
// Purpose: self-checking bench of the remote I/O control port
// Assumes: PULSE_CYC shortened to 8 cycles
// Notes: accepted commands are gathered in seen, cleared by seen_clr before each command
`timescale 1ns/100ps
`include "remote_io_regs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %h seen %h", n, e, g); end end
module remote_io_control_port_bench;
localparam PC = 8;
logic clock_i = 0;
logic nrst_i = 0;
logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [6:0] seen = 0;
logic seen_clr = 0;
int mismatches = 0, checks = 0;
wire awready, wready, bvalid, arready, rvalid, irq, motor, home, hipwr, cal_need, paused, alarm, hb_o, hb;
wire [1:0] bresp, rresp;
wire [31:0] rdata, pos, trq, load;
wire [6:0] pulse, cmd;
wire [5:0] sprog, pnum, psel;
wire [4:0] rsel, rrob;
wire [7:0] trig;
always #2.5 clock_i = ~clock_i;
always @(posedge clock_i) seen <= seen_clr ? 7'h00 : (seen | pulse);
remote_io_master_model #(.SETTLE(8)) u_plc (.clock_i(clock_i), .cmd_o(cmd), .heartbeat_o(hb),
    .robot_select_o(rsel), .program_select_o(psel), .trigger_o(trig));
remote_io_control_port #(.PULSE_CYC(PC)) u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .start_i(cmd[0]), .pause_i(cmd[1]), .continue_i(cmd[2]), .stop_i(cmd[3]), .motor_power_on_cmd_i(cmd[4]),
    .motor_power_off_cmd_i(cmd[5]), .home_i(cmd[6]), .heartbeat_i(hb), .robot_select_in_i(rsel),
    .program_select_in_i(psel), .trigger_i(trig), .cmd_pulse_o(pulse), .start_program_o(sprog),
    .program_number_out_o(pnum), .motor_power_flag_o(motor), .home_flag_o(home), .high_power_flag_o(hipwr),
    .calibration_needed_flag_o(cal_need), .paused_o(paused), .alarm_o(alarm), .heartbeat_o(hb_o),
    .position_o(pos), .torque_o(trq), .load_o(load), .report_robot_o(rrob), .irq_o(irq));
// ----------------------------------------
// bus cycles
// ----------------------------------------
// the slave takes address and data in one cycle, so both are released together
task automatic wr(input [5:0] a, input [31:0] d, input [1:0] er);
    @(posedge clock_i);
    awaddr <= {26'h0, a};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge clock_i); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge clock_i); while (!bvalid);
    bready <= 1'h0;
    `CHK("bresp", er, bresp)
endtask
task automatic rd(input [5:0] a, input [31:0] e, input [1:0] er);
    @(posedge clock_i);
    araddr <= {26'h0, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clock_i); while (!rvalid);
    rready <= 1'h0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
endtask
task automatic cmd_go(input [6:0] m, input int len, input [6:0] e);
    @(posedge clock_i);
    seen_clr <= 1'h1;
    @(posedge clock_i);
    seen_clr <= 1'h0;
    u_plc.pulse(m, len);
    `CHK("accepted", e, seen)
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_regs;
    rd(`RIO_CTRL, 32'h0, `RESP_OKAY);
    rd(6'h3C, 32'h0, `RESP_SLVERR);
    wr(6'h3C, 32'h1, `RESP_SLVERR);
    wr(`RIO_STATUS, 32'h1, `RESP_SLVERR);
    wr(`RIO_IRQ_MASK, 32'h3FF, `RESP_OKAY);
    rd(`RIO_IRQ_MASK, 32'h3FF, `RESP_OKAY);
endtask
task automatic t_prog;
    logic [5:0] v [8] = '{0, 1, 2, 3, 60, 61, 62, 63};
    foreach (v[i]) begin
        wr(`RIO_PROG, {26'h0, v[i]}, `RESP_OKAY);
        repeat (2) @(posedge clock_i);
        `CHK("program", v[i], pnum)
    end
endtask
task automatic t_flags;
    logic [4:0] s [7] = '{0, 1, 2, 3, 16, 17, 0};
    logic [3:0] e [7] = '{4'hB, 4'h5, 4'h6, 4'h8, 4'hC, 4'h0, 4'hF};
    wr(`RIO_MOTORS, 32'h8004, `RESP_OKAY);
    wr(`RIO_HOME, 32'hFFFB, `RESP_OKAY);
    wr(`RIO_HIPWR, 32'h0002, `RESP_OKAY);
    wr(`RIO_MACHINE_CALIBRATION, 32'hFFFE, `RESP_OKAY);
    foreach (s[i]) begin
        if (i == 6) wr(`RIO_HOME, 32'hFFFF, `RESP_OKAY);
        u_plc.select(s[i]);
        `CHK("flags", e[i], {motor, home, hipwr, cal_need})
        `CHK("report", (s[i] == 5'h00) ? 5'h01 : s[i], rrob)
    end
endtask
task automatic t_data;
    logic [31:0] al [4] = '{32'h0, 32'h10000, 32'h8000, 32'h0};
    wr(`RIO_POS, 32'h3F800000, `RESP_OKAY);
    wr(`RIO_TORQUE, 32'hC0490FDB, `RESP_OKAY);
    wr(`RIO_LOAD, 32'h0000002A, `RESP_OKAY);
    repeat (3) @(posedge clock_i);
    `CHK("position", 32'h3F800000, pos)
    `CHK("torque", 32'hC0490FDB, trq)
    `CHK("load", 32'h0000002A, load)
    foreach (al[i]) begin
        wr(`RIO_ALARM, al[i], `RESP_OKAY);
        repeat (3) @(posedge clock_i);
        `CHK("alarm", |al[i], alarm)
    end
endtask
task automatic t_cmds;
    wr(`RIO_CTRL, 32'h0, `RESP_OKAY);
    u_plc.prog(6'h2A);
    cmd_go(7'h01, PC + 8, 7'h00);
    rd(`RIO_IRQ_STAT, 32'h200, `RESP_OKAY);
    wr(`RIO_CTRL, 32'h3, `RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
        cmd_go(7'h01 << i, PC + 8, 7'h01 << i);
        `CHK("irq", 1'h1, irq)
        rd(`RIO_IRQ_STAT, 32'h1 << i, `RESP_OKAY);
        `CHK("irq", 1'h0, irq)
    end
    `CHK("start program", 6'h2A, sprog)
    rd(`RIO_STATUS, 32'h540A, `RESP_OKAY);
    wr(`RIO_CTRL, 32'hC, `RESP_OKAY);
    cmd_go(7'h40, PC + 8, 7'h40);
    wr(`RIO_CTRL, 32'h4, `RESP_OKAY);
    cmd_go(7'h40, PC + 8, 7'h00);
    rd(`RIO_IRQ_STAT, 32'h240, `RESP_OKAY);
endtask
task automatic t_limits;
    wr(`RIO_CTRL, 32'h3, `RESP_OKAY);
    cmd_go(7'h08, PC - 3, 7'h00);
    rd(`RIO_IRQ_STAT, 32'h0, `RESP_OKAY);
    wr(`RIO_IRQ_MASK, 32'h0, `RESP_OKAY);
    cmd_go(7'h0A, PC + 8, 7'h00);
    `CHK("irq", 1'h0, irq)
    wr(`RIO_IRQ_MASK, 32'h3FF, `RESP_OKAY);
    repeat (2) @(posedge clock_i);
    `CHK("irq", 1'h1, irq)
    rd(`RIO_IRQ_STAT, 32'h80, `RESP_OKAY);
endtask
task automatic t_pause;
    cmd_go(7'h02, PC + 8, 7'h02);
    `CHK("paused", 1'h0, paused)
    wr(`RIO_CTRL, 32'h23, `RESP_OKAY);
    repeat (3) @(posedge clock_i);
    `CHK("paused", 1'h1, paused)
    cmd_go(7'h04, PC + 8, 7'h04);
    `CHK("paused", 1'h0, paused)
    wr(`RIO_CTRL, 32'h13, `RESP_OKAY);
    cmd_go(7'h02, PC + 8, 7'h02);
    `CHK("paused", 1'h1, paused)
    cmd_go(7'h08, PC + 8, 7'h08);
    `CHK("paused", 1'h0, paused)
    rd(`RIO_IRQ_STAT, 32'h0E, `RESP_OKAY);
endtask
task automatic t_trig;
    wr(`RIO_POS, 32'h12345678, `RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
        u_plc.trig(k);
        rd(`RIO_TRIG_SRC, 32'h1 << k, `RESP_OKAY);
        rd(`RIO_TRIG_POS, 32'h12345678, `RESP_OKAY);
        rd(`RIO_IRQ_STAT, 32'h100, `RESP_OKAY);
    end
endtask
task automatic close_out;
    if (mismatches == 0 && checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    close_out;
end
initial begin
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'h1;
    t_regs;
    t_prog;
    t_flags;
    t_data;
    t_cmds;
    t_limits;
    t_pause;
    t_trig;
    close_out;
end
endmodule
